// ===== hdl/pif_flag_byte.sv
module pif_flag_byte
    import pif_pkg::*;
#(
    parameter logic [7:0] IMPL_MASK = 8'hFF
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] event_pulse,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] flags
);

    typedef struct packed {
        logic [7:0] flags;
    } pif_fb_state_t;

    pif_fb_state_t state_ff;
    pif_fb_state_t nxt_state;

    // Events are latched regardless of any enable; a same-cycle event beats
    // a software write of zero so it is never lost.
    always_comb begin
        nxt_state = state_ff;
        if (wr_en) begin
            nxt_state.flags = wr_data;
        end
        nxt_state.flags = (nxt_state.flags | event_pulse) & IMPL_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= '{flags: RESET_BYTE};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flags = state_ff.flags;

    event_sets_a: assert property (@(posedge clk) disable iff (rst)
        (|(event_pulse & IMPL_MASK)) |=> ((flags & $past(event_pulse & IMPL_MASK))
                                           == $past(event_pulse & IMPL_MASK)))
        else $error("event did not set its flag");

    flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
        (!wr_en) |=> ((flags & $past(flags)) == $past(flags)))
        else $error("flag cleared without a write");

endmodule : pif_flag_byte

// ===== hdl/pif_irq_ctrl.sv
module pif_irq_ctrl
    import pif_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  EVENT_A,
    input  wire logic [7:0]  EVENT_B,
    input  wire logic        IRQ_TAKEN,
    input  wire logic [15:0] RETURN_PC,
    output logic             CORE_IRQ,
    output logic [15:0]      SAVED_PC,
    output logic [15:0]      VECTOR_PC,
    output logic             VECTOR_LOAD
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  enable_a;
        logic [7:0]  enable_b;
        logic        global_irq_enable;
        logic        periph_group_enable;
        logic [31:0] rdata;
        logic [15:0] saved_pc;
        logic        vector_load;
        logic        core_irq;
    } pif_state_t;

    pif_state_t   state_ff;
    pif_state_t   nxt_state;
    pif_apb_req_t apb;
    pif_events_t  evt;
    pif_events_t  flag;
    logic         wr_access;
    logic         rd_access;
    logic         wr_flag_a;
    logic         wr_flag_b;
    logic         addr_ok;
    logic         pending;
    logic         request;

    assign apb = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE,
                   paddr: PADDR, pwdata: PWDATA};
    assign evt = '{a: EVENT_A, b: EVENT_B};

    // ------------------------------------------------------------------
    // APB decode: zero wait states, every access completes in its access phase
    // ------------------------------------------------------------------
    assign wr_access = apb.psel && apb.penable && apb.pwrite;
    assign rd_access = apb.psel && !apb.pwrite;
    assign wr_flag_a = wr_access && (apb.paddr == ADDR_FLAG_A);
    assign wr_flag_b = wr_access && (apb.paddr == ADDR_FLAG_B);

    always_comb begin
        unique case (apb.paddr)
            ADDR_ENABLE_A, ADDR_ENABLE_B, ADDR_FLAG_A,
            ADDR_FLAG_B, ADDR_MAIN_CTL, ADDR_CORE_ST: addr_ok = 1'b1;
            default:                                  addr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Flag registers; unused bits are masked inside each instance
    // ------------------------------------------------------------------
    pif_flag_byte #(.IMPL_MASK(MASK_A)) u_flag_a (
        .clk         (CLK),
        .rst         (RST),
        .event_pulse (evt.a),
        .wr_en       (wr_flag_a),
        .wr_data     (apb.pwdata[7:0]),
        .flags       (flag.a)
    );

    // Protection flags; their layout follows the enable register B layout
    pif_flag_byte #(.IMPL_MASK(MASK_B)) u_flag_b (
        .clk         (CLK),
        .rst         (RST),
        .event_pulse (evt.b),
        .wr_en       (wr_flag_b),
        .wr_data     (apb.pwdata[7:0]),
        .flags       (flag.b)
    );

    // ------------------------------------------------------------------
    // Request combine
    // ------------------------------------------------------------------
    assign pending = |((flag.a & state_ff.enable_a) | (flag.b & state_ff.enable_b));
    assign request = state_ff.global_irq_enable && state_ff.periph_group_enable
                     && pending;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.vector_load = 1'b0;
        nxt_state.core_irq    = request;
        if (wr_access) begin
            unique case (apb.paddr)
                ADDR_ENABLE_A: nxt_state.enable_a = apb.pwdata[7:0] & MASK_A;
                ADDR_ENABLE_B: nxt_state.enable_b = apb.pwdata[7:0] & MASK_B;
                ADDR_MAIN_CTL: begin
                    nxt_state.global_irq_enable   = apb.pwdata[BIT_GLOBAL_EN];
                    nxt_state.periph_group_enable = apb.pwdata[BIT_GROUP_EN];
                end
                default: ;
            endcase
        end
        // Taking the interrupt wins over a same-cycle software write of the enable
        if (IRQ_TAKEN && state_ff.core_irq) begin
            nxt_state.global_irq_enable = 1'b0;
            nxt_state.saved_pc          = RETURN_PC;
            nxt_state.vector_load       = 1'b1;
            nxt_state.core_irq          = 1'b0;
        end
        if (rd_access && !apb.penable) begin
            unique case (apb.paddr)
                ADDR_ENABLE_A: nxt_state.rdata = {24'h000000, state_ff.enable_a};
                ADDR_ENABLE_B: nxt_state.rdata = {24'h000000, state_ff.enable_b};
                ADDR_FLAG_A:   nxt_state.rdata = {24'h000000, flag.a};
                ADDR_FLAG_B:   nxt_state.rdata = {24'h000000, flag.b};
                ADDR_MAIN_CTL: nxt_state.rdata = {30'h00000000,
                                                  state_ff.global_irq_enable,
                                                  state_ff.periph_group_enable};
                ADDR_CORE_ST:  nxt_state.rdata = {15'h0000, state_ff.core_irq,
                                                  state_ff.saved_pc};
                default:       nxt_state.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= '{enable_a: RESET_BYTE, enable_b: RESET_BYTE,
                          global_irq_enable: 1'b0, periph_group_enable: 1'b0,
                          rdata: 32'h00000000, saved_pc: 16'h0000,
                          vector_load: 1'b0, core_irq: 1'b0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRDATA      = state_ff.rdata;
    assign PREADY      = 1'b1;
    assign PSLVERR     = apb.psel && apb.penable && !addr_ok;
    assign CORE_IRQ    = state_ff.core_irq;
    assign SAVED_PC    = state_ff.saved_pc;
    assign VECTOR_PC   = VECTOR_ADDR;
    assign VECTOR_LOAD = state_ff.vector_load;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    group_gate_a: assert property (@(posedge CLK) disable iff (RST)
        !state_ff.periph_group_enable |=> !CORE_IRQ)
        else $error("request without group enable");

    global_gate_a: assert property (@(posedge CLK) disable iff (RST)
        !state_ff.global_irq_enable |=> !CORE_IRQ)
        else $error("request without global enable");

    request_raise_a: assert property (@(posedge CLK) disable iff (RST)
        (state_ff.global_irq_enable && state_ff.periph_group_enable && pending
         && !IRQ_TAKEN) |=> CORE_IRQ)
        else $error("qualified request not raised");

    enable_block_a: assert property (@(posedge CLK) disable iff (RST)
        (pending == 1'b0) |=> !CORE_IRQ)
        else $error("request from a blocked source");

    unused_zero_a: assert property (@(posedge CLK) disable iff (RST)
        ((state_ff.enable_a & ~MASK_A) == 8'h00) && ((state_ff.enable_b & ~MASK_B) == 8'h00)
        && ((flag.a & ~MASK_A) == 8'h00) && ((flag.b & ~MASK_B) == 8'h00))
        else $error("unused bit is set");

    enable_write_a: assert property (@(posedge CLK) disable iff (RST)
        (wr_access && apb.paddr == ADDR_ENABLE_A) |=>
        (state_ff.enable_a == ($past(apb.pwdata[7:0]) & MASK_A)))
        else $error("enable register A write lost");

    take_clears_a: assert property (@(posedge CLK) disable iff (RST)
        (IRQ_TAKEN && CORE_IRQ) |=> (!state_ff.global_irq_enable && VECTOR_LOAD
                                     && SAVED_PC == $past(RETURN_PC)) ##1 !VECTOR_LOAD)
        else $error("interrupt take sequence wrong");

endmodule : pif_irq_ctrl

// ===== hdl/pif_pkg.sv
package pif_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ENABLE_A = 8'h00;
    localparam logic [7:0] ADDR_ENABLE_B = 8'h04;
    localparam logic [7:0] ADDR_FLAG_A   = 8'h08;
    localparam logic [7:0] ADDR_FLAG_B   = 8'h0C;
    localparam logic [7:0] ADDR_MAIN_CTL = 8'h10;
    localparam logic [7:0] ADDR_CORE_ST  = 8'h14;

    // ------------------------------------------------------------------
    // Implemented-bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MASK_A      = 8'h7F;
    localparam logic [7:0] MASK_B      = 8'h9F;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [1:0] MASK_CTL    = 2'h3;
    localparam logic [1:0] RESET_CTL   = 2'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_TIMER_ONE    = 0;
    localparam int BIT_TIMER_TWO    = 1;
    localparam int BIT_CAPCMP_ONE   = 2;
    localparam int BIT_CAPCMP_TWO   = 3;
    localparam int BIT_SERIAL_PORT  = 4;
    localparam int BIT_COLLISION    = 5;
    localparam int BIT_ADC_DONE     = 6;
    localparam int BIT_IN_UNDERVOLT = 0;
    localparam int BIT_IN_OVERVOLT  = 1;
    localparam int BIT_GATE_LOW     = 2;
    localparam int BIT_OUT_OVERVOLT = 3;
    localparam int BIT_OVERTEMP     = 4;
    localparam int BIT_DESATURATION_DETECT        = 7;
    localparam int BIT_GLOBAL_EN    = 1;
    localparam int BIT_GROUP_EN     = 0;

    localparam logic [15:0] VECTOR_ADDR = 16'h0004;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
    } pif_events_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pif_apb_req_t;

endpackage : pif_pkg

// ===== verification/pif_core_model.sv
module pif_core_model
    import pif_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        core_irq,
    input  wire logic        take_en,
    input  wire logic [3:0]  take_dly,
    output logic             irq_taken,
    output logic [15:0]      return_pc
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt;

    // Program counter keeps running so every take saves a fresh value
    always_ff @(posedge clk) begin
        if (rst) begin
            return_pc <= 16'h0100;
            wait_cnt  <= 4'h0;
            irq_taken <= 1'b0;
        end else begin
            return_pc <= return_pc + 16'h0001;
            irq_taken <= 1'b0;
            if (core_irq && take_en && !irq_taken) begin
                if (wait_cnt >= take_dly) begin
                    irq_taken <= 1'b1;
                    wait_cnt  <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule : pif_core_model

// ===== verification/pif_irq_ctrl_test.sv
module pif_irq_ctrl_test
    import pif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  ev_a = 8'h00;
    logic [7:0]  ev_b = 8'h00;
    logic        take_en = 1'b0;
    logic [3:0]  take_dly = 4'h0;
    logic        irq_taken, pready, pslverr, core_irq, vec_load, rerr;
    logic [15:0] ret_pc, exp_pc, saved_pc, vec_pc;
    logic [31:0] prdata, rdat;
    int          err_count = 0;
    int          cmp_count = 0;

    initial forever #10 clk = ~clk;

    pif_irq_ctrl dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EVENT_A(ev_a), .EVENT_B(ev_b), .IRQ_TAKEN(irq_taken), .RETURN_PC(ret_pc),
        .CORE_IRQ(core_irq), .SAVED_PC(saved_pc), .VECTOR_PC(vec_pc), .VECTOR_LOAD(vec_load));

    pif_core_model core (.clk(clk), .rst(rst), .core_irq(core_irq), .take_en(take_en),
        .take_dly(take_dly), .irq_taken(irq_taken), .return_pc(ret_pc));

    always @(posedge clk) if (irq_taken && core_irq) exp_pc <= ret_pc;

    // ------------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask : wr

    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, {24'h0, exp}, rdat);
    endtask : rd

    // Event high for one cycle, then time for flag and request to settle
    task automatic pulse(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        ev_a <= a;
        ev_b <= b;
        @(posedge clk);
        ev_a <= 8'h00;
        ev_b <= 8'h00;
        repeat (3) @(posedge clk);
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd("enable a", ADDR_ENABLE_A, 8'h00);
        rd("enable b", ADDR_ENABLE_B, 8'h00);
        rd("flag a", ADDR_FLAG_A, 8'h00);
        rd("main control", ADDR_MAIN_CTL, 8'h00);
        chk("core request", 32'h0, {31'h0, core_irq});
    endtask : t_reset

    task automatic t_access;
        wr(ADDR_ENABLE_A, 8'hFF);
        rd("enable a", ADDR_ENABLE_A, 8'h7F);
        wr(ADDR_ENABLE_B, 8'hFF);
        rd("enable b", ADDR_ENABLE_B, 8'h9F);
        wr(ADDR_FLAG_A, 8'hFF);
        rd("flag a", ADDR_FLAG_A, 8'h7F);
        wr(ADDR_FLAG_A, 8'h00);
        rd("flag a clear", ADDR_FLAG_A, 8'h00);
        wr(ADDR_ENABLE_A, 8'h00);
        wr(ADDR_ENABLE_B, 8'h00);
        wr(8'h20, 8'hFF);
        rd("unmapped", 8'h20, 8'h00);
        chk("slave error", 32'h1, {31'h0, rerr});
    endtask : t_access

    // All enables off: flags must still latch and hold until written
    task automatic t_flags;
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i, 8'h00);
            rd("flag set", ADDR_FLAG_A, (8'h01 << i) & 8'h7F);
            chk("masked request", 32'h0, {31'h0, core_irq});
            repeat (5) @(posedge clk);
            rd("flag held", ADDR_FLAG_A, (8'h01 << i) & 8'h7F);
            wr(ADDR_FLAG_A, 8'h00);
            rd("flag cleared", ADDR_FLAG_A, 8'h00);
        end
    endtask : t_flags

    task automatic t_gate;
        logic [7:0] m;
        logic [7:0] b;
        wr(ADDR_MAIN_CTL, 8'h02);
        wr(ADDR_ENABLE_A, 8'h01);
        pulse(8'h01, 8'h00);
        chk("group gate", 32'h0, {31'h0, core_irq});
        wr(ADDR_MAIN_CTL, 8'h03);
        repeat (2) @(posedge clk);
        chk("request", 32'h1, {31'h0, core_irq});
        wr(ADDR_MAIN_CTL, 8'h01);
        repeat (2) @(posedge clk);
        chk("global gate", 32'h0, {31'h0, core_irq});
        wr(ADDR_MAIN_CTL, 8'h03);
        wr(ADDR_FLAG_A, 8'h00);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 8; i++) begin
                m = r ? MASK_B : MASK_A;
                b = 8'h01 << i;
                wr(r ? ADDR_ENABLE_B : ADDR_ENABLE_A, m & ~b);
                pulse(r ? 8'h00 : b, r ? b : 8'h00);
                chk("other enables", 32'h0, {31'h0, core_irq});
                wr(r ? ADDR_ENABLE_B : ADDR_ENABLE_A, b);
                repeat (2) @(posedge clk);
                chk("own enable", {31'h0, m[i]}, {31'h0, core_irq});
                wr(r ? ADDR_FLAG_B : ADDR_FLAG_A, 8'h00);
                wr(r ? ADDR_ENABLE_B : ADDR_ENABLE_A, 8'h00);
            end
        end
    endtask : t_gate

    // Slow take first, then a prompt one with the flag still pending
    task automatic t_take;
        int n;
        wr(ADDR_ENABLE_A, 8'h02);
        pulse(8'h02, 8'h00);
        for (int k = 0; k < 2; k++) begin
            take_dly <= k ? 4'h0 : 4'h5;
            take_en  <= 1'b1;
            n = 0;
            while (vec_load !== 1'b1 && n < 30) begin
                @(posedge clk);
                n++;
            end
            take_en <= 1'b0;
            chk("vector load", 32'h1, {31'h0, vec_load});
            chk("vector", {16'h0, VECTOR_ADDR}, {16'h0, vec_pc});
            chk("saved pc", {16'h0, exp_pc}, {16'h0, saved_pc});
            chk("request dropped", 32'h0, {31'h0, core_irq});
            @(posedge clk);
            chk("load pulse", 32'h0, {31'h0, vec_load});
            rd("global cleared", ADDR_MAIN_CTL, 8'h01);
            wr(ADDR_MAIN_CTL, 8'h03);
        end
    endtask : t_take

    task automatic test_done;
        if (err_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_access();
        t_flags();
        t_gate();
        t_take();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule : pif_irq_ctrl_test
